// ### src/twt_dev_end.sv
// Device end: serial command decoder, settings register, conversion control.
// Assumes link pins are asynchronous to mclk and sample_value is on mclk.
//
// Contract
// - Host mode: conversions only by serial commands
// - Stand-alone: pin low runs continuous conversions
// - Short low pulse gives exactly one conversion
// - Stand-alone ignores single bit; pin decides
// - Bus start halts stand-alone; command runs persist
// - Eight-bit settings register, read ACh, write 0Ch
// - Done bit low while converting, else high
// - Sticky limit flags, cleared by zero write
// - Busy bit high during nonvolatile write
// - Resolution bits pick 9 to 12 bits
// - Single bit picks one-shot or continuous start
// - Select high starts frame, low ends, releases
// - Host holds write data around rising edge
// - Read bits driven at fall, released after rise
// - Opcode first, all bits LSB first
// - Commit only after full data count arrives
// - Read data follows opcode, then zeros
// - 51h starts, 22h stops continuous conversions
// - AAh, A1h, A2h return twelve-bit registers
// - 01h, 02h load the limit registers
// - 54h clears flags and measurement, stops conversion
// - Host waits 10 ms between writes
// - Measurement twelve-bit signed, unused LSBs zero
// - Limit bits below resolution forced zero
`timescale 1ns/10ps
module twt_dev_end
  import twt_pkg::*;
#(
  parameter int CONV9_CYC_P   = CONV9_CYC,
  parameter int ONESHOT_CYC_P = ONESHOT_CYC,
  parameter int NV_CYC_P      = NV_CYC
) (
  // Link
  twt_if.dev                 link,
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              resetn,
  // Converter core
  input  wire logic [MEAS_W-1:0] sample_value,
  output logic                   conv_busy,
  output logic                   sample_strobe
);

  // ------------------------------------------------------------------
  // Parameter check
  // ------------------------------------------------------------------
  if (CONV9_CYC_P < 1 || CONV9_CYC_P > 32'h0FFF_FFFF || ONESHOT_CYC_P < 1 || NV_CYC_P < 1)
  begin : g_bad_param
    $error("twt_dev_end: cycle counts out of range");
  end

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  logic        sel_s1_q, sel_s2_q, sclk_s1_q, sclk_s2_q, sclk_s3_q, io_s1_q, io_s2_q;
  logic [4:0]  bit_cnt_q, bit_cnt_d;
  logic [7:0]  op_q, op_d;
  logic [11:0] wd_q, wd_d, sh_q, sh_d;
  logic        rd_q, rd_d, oe_n_q, oe_n_d, dout_q, dout_d;
  logic [11:0] ul_q, ul_d, ll_q, ll_d, meas_q, meas_d;
  logic        ul_flag_q, ul_flag_d, ll_flag_q, ll_flag_d;
  logic [1:0]  res_q, res_d;
  logic        host_q, host_d, single_q, single_d;
  logic [31:0] nv_cnt_q, nv_cnt_d, conv_cnt_q, conv_cnt_d, low_cnt_q, low_cnt_d;
  twt_conv_e   cv_q, cv_d;
  logic        cmd_cont_q, cmd_cont_d, sa_own_q, sa_own_d, sa_held_q, sa_held_d;
  logic        busy_q, busy_d, stb_q, stb_d;
  logic        sclk_rise, sclk_fall, sa_en, pin_low;
  logic [7:0]  cfg_rd;

  function automatic logic [11:0] res_mask(input logic [1:0] r);
    res_mask = 12'(12'hFFF << (2'h3 - r));
  endfunction

  function automatic logic [31:0] conv_cyc(input logic [1:0] r);
    conv_cyc = 32'(CONV9_CYC_P) << r;
  endfunction

  assign sclk_rise = sclk_s2_q & ~sclk_s3_q;
  assign sclk_fall = ~sclk_s2_q & sclk_s3_q;
  assign sa_en     = ~host_q & ~sel_s2_q;
  // Serial clock doubles as convert input while deselected
  assign pin_low   = ~sclk_s2_q;
  assign cfg_rd    = {cv_q == CV_IDLE, ul_flag_q, ll_flag_q, nv_cnt_q != 32'h0,
                      res_q, host_q, single_q};

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    logic [7:0]  op_next;
    logic [11:0] wd_next;
    logic [11:0] m;
    logic        cmd_start, cmd_stop, cmd_por, start, abort;
    op_next    = {io_s2_q, op_q[7:1]};
    wd_next    = {io_s2_q, wd_q[11:1]};
    m          = sample_value & res_mask(res_q);
    cmd_start  = 1'b0;
    cmd_stop   = 1'b0;
    cmd_por    = 1'b0;
    start      = 1'b0;
    abort      = 1'b0;
    bit_cnt_d  = bit_cnt_q;
    op_d       = op_q;
    wd_d       = wd_q;
    sh_d       = sh_q;
    rd_d       = rd_q;
    oe_n_d     = oe_n_q;
    dout_d     = dout_q;
    ul_d       = ul_q;
    ll_d       = ll_q;
    meas_d     = meas_q;
    ul_flag_d  = ul_flag_q;
    ll_flag_d  = ll_flag_q;
    res_d      = res_q;
    host_d     = host_q;
    single_d   = single_q;
    nv_cnt_d   = (nv_cnt_q != 32'h0) ? nv_cnt_q - 32'h1 : nv_cnt_q;
    conv_cnt_d = conv_cnt_q;
    low_cnt_d  = low_cnt_q;
    cv_d       = cv_q;
    cmd_cont_d = cmd_cont_q;
    sa_own_d   = sa_own_q;
    sa_held_d  = sa_held_q;
    stb_d      = 1'b0;

    // Serial frame
    if (!sel_s2_q) begin
      bit_cnt_d = 5'h0;
      rd_d      = 1'b0;
      oe_n_d    = 1'b1;
      dout_d    = 1'b0;
    end else begin
      if (sclk_rise) begin
        oe_n_d = 1'b1;
        if (bit_cnt_q != CNT_SAT) begin
          bit_cnt_d = bit_cnt_q + 5'h1;
        end
        if (bit_cnt_q < 5'(OP_BITS)) begin
          op_d = op_next;
        end else begin
          wd_d = wd_next;
        end
        if (bit_cnt_q == OP_LAST) begin
          case (op_next)
            OP_START:    cmd_start = 1'b1;
            OP_STOP:     cmd_stop  = 1'b1;
            OP_SOFT_POR: cmd_por   = 1'b1;
            OP_RD_MEAS:  begin rd_d = 1'b1; sh_d = meas_q; end
            OP_RD_UL:    begin rd_d = 1'b1; sh_d = ul_q; end
            OP_RD_LL:    begin rd_d = 1'b1; sh_d = ll_q; end
            OP_RD_CFG:   begin rd_d = 1'b1; sh_d = {4'h0, cfg_rd}; end
            default:     ;
          endcase
        end
        if (bit_cnt_q == LIM_LAST && op_q == OP_WR_UL) begin
          ul_d     = wd_next & res_mask(res_q);
          nv_cnt_d = 32'(NV_CYC_P);
        end
        if (bit_cnt_q == LIM_LAST && op_q == OP_WR_LL) begin
          ll_d     = wd_next & res_mask(res_q);
          nv_cnt_d = 32'(NV_CYC_P);
        end
        if (bit_cnt_q == CFG_LAST && op_q == OP_WR_CFG) begin
          ul_flag_d = wd_next[4 + CFG_UL_FLAG];
          ll_flag_d = wd_next[4 + CFG_LL_FLAG];
          res_d     = wd_next[4 + CFG_RES_LSB +: 2];
          host_d    = wd_next[4 + CFG_HOST];
          single_d  = wd_next[4 + CFG_SINGLE];
          nv_cnt_d  = 32'(NV_CYC_P);
        end
      end
      if (sclk_fall && rd_q) begin
        oe_n_d = 1'b0;
        dout_d = sh_q[0];
        sh_d   = {1'b0, sh_q[11:1]};
      end
    end

    // Stand-alone convert pin
    if (!pin_low || !sa_en) begin
      low_cnt_d = 32'h0;
    end else if (low_cnt_q != 32'(ONESHOT_CYC_P)) begin
      low_cnt_d = low_cnt_q + 32'h1;
    end
    if (!pin_low) begin
      sa_held_d = 1'b0;
    end
    if (sa_en && pin_low && !sa_held_q && cv_q == CV_IDLE) begin
      start     = 1'b1;
      sa_own_d  = 1'b1;
      sa_held_d = 1'b1;
    end
    // Long hold stops at release; short pulse lets the one run finish
    if (sa_en && sclk_rise && sa_own_q && low_cnt_q == 32'(ONESHOT_CYC_P)) begin
      abort = 1'b1;
    end
    if (sel_s2_q && sa_own_q) begin
      abort = 1'b1;
    end
    if (cmd_start) begin
      start      = 1'b1;
      sa_own_d   = 1'b0;
      cmd_cont_d = ~single_q;
    end
    if (cmd_stop && !single_q) begin
      cmd_cont_d = 1'b0;
      abort      = ~sa_own_q;
    end

    // Conversion timer
    if (start) begin
      cv_d       = CV_RUN;
      conv_cnt_d = conv_cyc(res_q);
    end else if (abort) begin
      cv_d     = CV_IDLE;
      sa_own_d = 1'b0;
    end else if (cv_q == CV_RUN) begin
      if (conv_cnt_q == 32'h0) begin
        meas_d = m;
        stb_d  = 1'b1;
        ul_flag_d = ul_flag_d | ($signed(m) >= $signed(ul_q));
        ll_flag_d = ll_flag_d | ($signed(m) <= $signed(ll_q));
        if ((!sa_own_q && cmd_cont_q) || (sa_own_q && sa_en && pin_low)) begin
          conv_cnt_d = conv_cyc(res_q);
        end else begin
          cv_d     = CV_IDLE;
          sa_own_d = 1'b0;
        end
      end else begin
        conv_cnt_d = conv_cnt_q - 32'h1;
      end
    end

    if (cmd_por) begin
      cv_d       = CV_IDLE;
      cmd_cont_d = 1'b0;
      sa_own_d   = 1'b0;
      ul_flag_d  = 1'b0;
      ll_flag_d  = 1'b0;
      meas_d     = 12'h0;
      nv_cnt_d   = 32'h0;
      conv_cnt_d = 32'h0;
    end
    busy_d = (cv_d == CV_RUN);
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sel_s1_q <= 1'b0; sel_s2_q <= 1'b0;
      sclk_s1_q <= 1'b1; sclk_s2_q <= 1'b1; sclk_s3_q <= 1'b1;
      io_s1_q <= 1'b1; io_s2_q <= 1'b1;
      bit_cnt_q <= 5'h0; op_q <= 8'h0; wd_q <= 12'h0; sh_q <= 12'h0;
      rd_q <= 1'b0; oe_n_q <= 1'b1; dout_q <= 1'b0;
      ul_q <= UL_RESET; ll_q <= LL_RESET; meas_q <= 12'h0;
      ul_flag_q <= 1'b0; ll_flag_q <= 1'b0;
      res_q <= RES_RESET; host_q <= HOST_RESET; single_q <= SINGLE_RESET;
      nv_cnt_q <= 32'h0; conv_cnt_q <= 32'h0; low_cnt_q <= 32'h0;
      cv_q <= CV_IDLE; cmd_cont_q <= 1'b0; sa_own_q <= 1'b0; sa_held_q <= 1'b0;
      busy_q <= 1'b0; stb_q <= 1'b0;
    end else begin
      sel_s1_q <= link.select_n; sel_s2_q <= sel_s1_q;
      sclk_s1_q <= link.sclk; sclk_s2_q <= sclk_s1_q; sclk_s3_q <= sclk_s2_q;
      io_s1_q <= link.io_level; io_s2_q <= io_s1_q;
      bit_cnt_q <= bit_cnt_d; op_q <= op_d; wd_q <= wd_d; sh_q <= sh_d;
      rd_q <= rd_d; oe_n_q <= oe_n_d; dout_q <= dout_d;
      ul_q <= ul_d; ll_q <= ll_d; meas_q <= meas_d;
      ul_flag_q <= ul_flag_d; ll_flag_q <= ll_flag_d;
      res_q <= res_d; host_q <= host_d; single_q <= single_d;
      nv_cnt_q <= nv_cnt_d; conv_cnt_q <= conv_cnt_d; low_cnt_q <= low_cnt_d;
      cv_q <= cv_d; cmd_cont_q <= cmd_cont_d; sa_own_q <= sa_own_d; sa_held_q <= sa_held_d;
      busy_q <= busy_d; stb_q <= stb_d;
    end
  end

  assign link.dev_io_o    = dout_q;
  assign link.dev_io_oe_n = oe_n_q;
  assign conv_busy        = busy_q;
  assign sample_strobe    = stb_q;

endmodule // twt_dev_end

// ### src/twt_pkg.sv
// Shared constants for the three-wire thermometer command port.
// Assumes mclk at 125 MHz; long counts are overridable by module parameters.
package twt_pkg;

  // ------------------------------------------------------------------
  // Opcodes
  // ------------------------------------------------------------------
  localparam logic [7:0] OP_START    = 8'h51;
  localparam logic [7:0] OP_STOP     = 8'h22;
  localparam logic [7:0] OP_SOFT_POR = 8'h54;
  localparam logic [7:0] OP_RD_MEAS  = 8'hAA;
  localparam logic [7:0] OP_RD_UL    = 8'hA1;
  localparam logic [7:0] OP_RD_LL    = 8'hA2;
  localparam logic [7:0] OP_WR_UL    = 8'h01;
  localparam logic [7:0] OP_WR_LL    = 8'h02;
  localparam logic [7:0] OP_RD_CFG   = 8'hAC;
  localparam logic [7:0] OP_WR_CFG   = 8'h0C;

  // ------------------------------------------------------------------
  // Settings register fields and reset values
  // ------------------------------------------------------------------
  localparam int CFG_DONE    = 7;
  localparam int CFG_UL_FLAG = 6;
  localparam int CFG_LL_FLAG = 5;
  localparam int CFG_NVB     = 4;
  localparam int CFG_RES_MSB = 3;
  localparam int CFG_RES_LSB = 2;
  localparam int CFG_HOST    = 1;
  localparam int CFG_SINGLE  = 0;
  localparam logic [1:0] RES_RESET    = 2'h3;
  localparam logic       HOST_RESET   = 1'b0;
  localparam logic       SINGLE_RESET = 1'b0;
  localparam logic [11:0] UL_RESET    = 12'h7F0;
  localparam logic [11:0] LL_RESET    = 12'h800;

  // ------------------------------------------------------------------
  // Frame layout
  // ------------------------------------------------------------------
  localparam int MEAS_W   = 12;
  localparam int OP_BITS  = 8;
  localparam int LIM_BITS = 12;
  localparam int CFG_BITS = 8;
  localparam logic [4:0] OP_LAST  = 5'(OP_BITS - 1);
  localparam logic [4:0] CFG_LAST = 5'(OP_BITS + CFG_BITS - 1);
  localparam logic [4:0] LIM_LAST = 5'(OP_BITS + LIM_BITS - 1);
  localparam logic [4:0] CNT_SAT  = 5'h1F;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int MCLK_MHZ       = 125;
  localparam int CONV9_TIME_US  = 93750;
  localparam int ONESHOT_TIME_US = 10000;
  localparam int NV_TIME_US     = 10000;
  localparam int CONV9_CYC      = CONV9_TIME_US * MCLK_MHZ;
  localparam int ONESHOT_CYC    = ONESHOT_TIME_US * MCLK_MHZ;
  localparam int NV_CYC         = NV_TIME_US * MCLK_MHZ;
  localparam int HOST_HALF_CYC  = 5;
  localparam int HOST_SAMPLE_OFS = 2;

  // ------------------------------------------------------------------
  // State types
  // ------------------------------------------------------------------
  typedef enum logic {
    CV_IDLE = 1'b0,
    CV_RUN  = 1'b1
  } twt_conv_e;

  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_SETUP = 3'b001,
    H_LOW   = 3'b010,
    H_HIGH  = 3'b011,
    H_END   = 3'b100,
    H_GAP   = 3'b101
  } twt_host_e;

endpackage

// ### src/twt_if.sv
// Three-wire link between host and thermometer.
// Resolves the shared data wire from the two enables; pulled high when idle.
`timescale 1ns/10ps
interface twt_if;
  logic select_n;
  logic sclk;
  logic host_io_o;
  logic host_io_oe_n;
  logic dev_io_o;
  logic dev_io_oe_n;
  logic io_level;

  assign io_level = !dev_io_oe_n ? dev_io_o : (!host_io_oe_n ? host_io_o : 1'b1);

  modport dev  (input select_n, input sclk, input io_level,
                output dev_io_o, output dev_io_oe_n);
  modport host (input io_level,
                output select_n, output sclk, output host_io_o, output host_io_oe_n);
endinterface

// ### src/twt_host_end.sv
// Host end: runs one three-wire transaction per accepted command.
// Assumes the device end on the same link; makes the serial clock itself.
`timescale 1ns/10ps
module twt_host_end
  import twt_pkg::*;
#(
  parameter int HALF_CYC   = HOST_HALF_CYC,
  parameter int SAMPLE_OFS = HOST_SAMPLE_OFS,
  parameter int WR_GAP_CYC = NV_CYC
) (
  // Link
  twt_if.host        link,
  // Clock and reset
  input  wire logic  mclk,
  input  wire logic  resetn,
  // Command port
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_op,
  input  wire logic [11:0] cmd_wdata,
  output logic             cmd_ready,
  output logic             rsp_valid,
  output logic [11:0]      rsp_data
);

  // ------------------------------------------------------------------
  // Parameter check
  // ------------------------------------------------------------------
  // Device sees edges through a synchroniser, so phases must be long enough
  if (HALF_CYC < 5 || SAMPLE_OFS < 2 || SAMPLE_OFS >= HALF_CYC || WR_GAP_CYC < 1)
  begin : g_bad_param
    $error("twt_host_end: link timing parameters out of range");
  end

  function automatic logic [4:0] data_bits(input logic [7:0] op);
    case (op)
      OP_RD_MEAS, OP_RD_UL, OP_RD_LL, OP_WR_UL, OP_WR_LL: data_bits = 5'(LIM_BITS);
      OP_RD_CFG, OP_WR_CFG:                               data_bits = 5'(CFG_BITS);
      default:                                            data_bits = 5'h0;
    endcase
  endfunction

  twt_host_e   st_q, st_d;
  logic [31:0] ph_q, ph_d, gap_q, gap_d;
  logic [4:0]  idx_q, idx_d, nbits_q, nbits_d;
  logic [19:0] tx_q, tx_d;
  logic [11:0] rx_q, rx_d, rsp_q, rsp_d;
  logic        rd_q, rd_d, wr_q, wr_d;
  logic        sel_q, sel_d, sclk_q, sclk_d, io_q, io_d, oe_n_q, oe_n_d;
  logic        rdy_q, rdy_d, rv_q, rv_d;
  logic        io_s1_q, io_s2_q;
  logic        ph_end;

  assign ph_end = (ph_q == 32'(HALF_CYC - 1));

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    st_d    = st_q;
    ph_d    = ph_end ? 32'h0 : ph_q + 32'h1;
    gap_d   = (gap_q != 32'h0) ? gap_q - 32'h1 : gap_q;
    idx_d   = idx_q;
    nbits_d = nbits_q;
    tx_d    = tx_q;
    rx_d    = rx_q;
    rsp_d   = rsp_q;
    rd_d    = rd_q;
    wr_d    = wr_q;
    sel_d   = sel_q;
    sclk_d  = sclk_q;
    io_d    = io_q;
    oe_n_d  = oe_n_q;
    rv_d    = 1'b0;
    case (st_q)
      H_IDLE: begin
        ph_d = 32'h0;
        if (cmd_valid && rdy_q) begin
          st_d    = H_SETUP;
          sel_d   = 1'b1;
          tx_d    = {cmd_wdata, cmd_op};
          nbits_d = 5'(OP_BITS) + data_bits(cmd_op);
          rd_d    = cmd_op[7];
          wr_d    = ~cmd_op[7] && data_bits(cmd_op) != 5'h0;
          idx_d   = 5'h0;
        end
      end
      H_SETUP: begin
        if (ph_end) begin
          st_d   = H_LOW;
          sclk_d = 1'b0;
          io_d   = tx_q[0];
          oe_n_d = 1'b0;
          tx_d   = {1'b0, tx_q[19:1]};
        end
      end
      H_LOW: begin
        if (ph_end) begin
          st_d   = H_HIGH;
          sclk_d = 1'b1;
        end
      end
      H_HIGH: begin
        if (ph_q == 32'(SAMPLE_OFS) && rd_q && idx_q >= 5'(OP_BITS)) begin
          rx_d = {io_s2_q, rx_q[11:1]};
        end
        if (ph_end) begin
          if (idx_q == nbits_q - 5'h1) begin
            st_d   = H_END;
            oe_n_d = 1'b1;
          end else begin
            st_d   = H_LOW;
            idx_d  = idx_q + 5'h1;
            sclk_d = 1'b0;
            // Release the wire before the device drives read data
            oe_n_d = rd_q && (idx_q + 5'h1 >= 5'(OP_BITS));
            io_d   = tx_q[0];
            tx_d   = {1'b0, tx_q[19:1]};
          end
        end
      end
      H_END: begin
        if (ph_end) begin
          st_d  = H_GAP;
          sel_d = 1'b0;
          rv_d  = rd_q;
          rsp_d = (nbits_q == 5'(OP_BITS + CFG_BITS)) ? {4'h0, rx_q[11:4]} : rx_q;
          if (wr_q) begin
            gap_d = 32'(WR_GAP_CYC);
          end
        end
      end
      H_GAP: begin
        if (ph_end) begin
          st_d = H_IDLE;
        end
      end
      default: st_d = H_IDLE;
    endcase
    rdy_d = (st_d == H_IDLE) && (gap_d == 32'h0);
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_q <= H_IDLE; ph_q <= 32'h0; gap_q <= 32'h0;
      idx_q <= 5'h0; nbits_q <= 5'h0; tx_q <= 20'h0; rx_q <= 12'h0; rsp_q <= 12'h0;
      rd_q <= 1'b0; wr_q <= 1'b0;
      sel_q <= 1'b0; sclk_q <= 1'b1; io_q <= 1'b0; oe_n_q <= 1'b1;
      rdy_q <= 1'b0; rv_q <= 1'b0; io_s1_q <= 1'b1; io_s2_q <= 1'b1;
    end else begin
      st_q <= st_d; ph_q <= ph_d; gap_q <= gap_d;
      idx_q <= idx_d; nbits_q <= nbits_d; tx_q <= tx_d; rx_q <= rx_d; rsp_q <= rsp_d;
      rd_q <= rd_d; wr_q <= wr_d;
      sel_q <= sel_d; sclk_q <= sclk_d; io_q <= io_d; oe_n_q <= oe_n_d;
      rdy_q <= rdy_d; rv_q <= rv_d; io_s1_q <= link.io_level; io_s2_q <= io_s1_q;
    end
  end

  assign link.select_n     = sel_q;
  assign link.sclk         = sclk_q;
  assign link.host_io_o    = io_q;
  assign link.host_io_oe_n = oe_n_q;
  assign cmd_ready         = rdy_q;
  assign rsp_valid         = rv_q;
  assign rsp_data          = rsp_q;

endmodule // twt_host_end

// ### bench/twt_link_monitor.sv
// Checker on the three-wire link wires.
// Assumes host and device ends share one interface, sampled on mclk.
`timescale 1ns/10ps
module twt_link_monitor (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Link wires
  input wire logic select_n,
  input wire logic sclk,
  input wire logic host_io_o,
  input wire logic host_io_oe_n,
  input wire logic dev_io_o,
  input wire logic dev_io_oe_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);

  // --------------------
  // Frame tracking
  // --------------------
  logic [4:0] fall_q;
  // Saturates so long read tails cannot wrap back into the opcode
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) fall_q <= 5'h00;
    else fall_q <= select_n ? fall_q + 5'($fell(sclk) && fall_q != 5'h1F) : 5'h00;
  end

  sequence setup_s;
    (sclk && host_io_oe_n) [*3] ##[1:3] (!sclk && !host_io_oe_n);
  endsequence

  // --------------------
  // Properties
  // --------------------
  frame_setup_a: assert property ($rose(select_n) |-> setup_s)
    else $error("frame start without setup then opcode drive");
  idle_release_a: assert property (!select_n [*6] |-> dev_io_oe_n)
    else $error("device drives data while deselected");
  idle_clock_a: assert property (!select_n |-> sclk && host_io_oe_n)
    else $error("link not idle while deselected");
  no_contention_a: assert property (!(!dev_io_oe_n && !host_io_oe_n))
    else $error("both ends drive the data wire");
  drive_on_fall_a: assert property ($fell(dev_io_oe_n) |-> !sclk && select_n)
    else $error("device drive began outside a low clock phase");
  release_on_rise_a: assert property ($rose(sclk) |-> ##[0:6] dev_io_oe_n)
    else $error("device kept driving after clock rise");
  read_bit_hold_a: assert property (!dev_io_oe_n && !$past(dev_io_oe_n) |-> $stable(dev_io_o))
    else $error("read bit changed while driven");
  opcode_quiet_a: assert property (!dev_io_oe_n |-> fall_q >= 5'h09)
    else $error("device drove during the opcode");
  write_hold_a: assert property (sclk && !host_io_oe_n |-> $stable(host_io_o))
    else $error("host data moved during high clock phase");
endmodule // twt_link_monitor

// ### bench/three_wire_thermometer_command_port_tb.sv
// Bench joining host and device ends over the three-wire link.
// Drives the host command port and converter input; counts shortened.
`timescale 1ns/10ps
module three_wire_thermometer_command_port_tb
  import twt_pkg::*;
();
  logic        mclk         = 1'b0;
  logic        resetn       = 1'b0;
  logic        cmd_valid    = 1'b0;
  logic [7:0]  cmd_op       = 8'h00;
  logic [11:0] cmd_wdata    = 12'h000;
  logic [11:0] sample_value = 12'h000;
  logic        cmd_ready;
  logic        rsp_valid;
  logic [11:0] rsp_data;
  logic        conv_busy;
  logic        sample_strobe;
  logic [11:0] rdata;
  int          err_count    = 0;
  int          total_checks = 0;
  int          cycles       = 0;

  twt_if link ();
  // Busy window outlasts the host gap, so a settings read right after a write sees it
  twt_dev_end #(.CONV9_CYC_P(40), .ONESHOT_CYC_P(40), .NV_CYC_P(150)) twt_dev_end_inst (
    .link(link), .mclk(mclk), .resetn(resetn), .sample_value(sample_value),
    .conv_busy(conv_busy), .sample_strobe(sample_strobe));
  twt_host_end #(.WR_GAP_CYC(10)) twt_host_end_inst (
    .link(link), .mclk(mclk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  twt_link_monitor twt_link_monitor_inst (.mclk(mclk), .resetn(resetn),
    .select_n(link.select_n), .sclk(link.sclk), .host_io_o(link.host_io_o),
    .host_io_oe_n(link.host_io_oe_n), .dev_io_o(link.dev_io_o), .dev_io_oe_n(link.dev_io_oe_n));

  always #4 mclk = ~mclk;

  // --------------------
  // Shared tasks
  // --------------------
  task automatic stop_test();
    if (err_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One frame; read data kept only if the response pulse shows up
  task automatic run(input logic [7:0] op, input logic [11:0] wd);
    rdata = 'x;
    while (cmd_ready !== 1'b1) @(posedge mclk);
    cmd_op    <= op;
    cmd_wdata <= wd;
    cmd_valid <= 1'b1;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    do @(posedge mclk); while (cmd_ready === 1'b1);
    do begin
      if (rsp_valid === 1'b1) rdata = rsp_data;
      @(posedge mclk);
    end while (cmd_ready !== 1'b1);
  endtask

  // --------------------
  // Scenarios
  // --------------------
  task automatic t_reset_vals();
    run(OP_RD_CFG, 12'h000);
    check(rdata, {4'h0, 1'b1, 3'h0, RES_RESET, HOST_RESET, SINGLE_RESET});
    run(OP_RD_UL, 12'h000);
    check(rdata, UL_RESET);
    run(OP_RD_LL, 12'h000);
    check(rdata, LL_RESET);
  endtask

  task automatic t_limits();
    run(OP_WR_UL, 12'h5A3);
    run(OP_RD_UL, 12'h000);
    check(rdata, 12'h5A3);
    run(OP_WR_LL, 12'hFA5);
    run(OP_RD_LL, 12'h000);
    check(rdata, 12'hFA5);
    run(OP_WR_CFG, 12'h003);
    run(OP_RD_CFG, 12'h000);
    check(rdata, 12'h093);
    run(OP_WR_UL, 12'h127);
    run(OP_RD_UL, 12'h000);
    check(rdata, 12'h120);
  endtask

  task automatic t_oneshot();
    sample_value <= 12'h12F;
    run(OP_START, 12'h000);
    check({11'h0, conv_busy}, 12'h001);
    while (sample_strobe !== 1'b1) @(posedge mclk);
    // Long enough for a second conversion to show if one were started
    repeat (60) @(posedge mclk);
    check({11'h0, conv_busy}, 12'h000);
    run(OP_RD_MEAS, 12'h000);
    check(rdata, 12'h128);
    run(OP_RD_CFG, 12'h000);
    check(rdata, 12'h0C3);
    // Below the lower limit; upper flag must stay set
    sample_value <= 12'hF00;
    run(OP_START, 12'h000);
    while (sample_strobe !== 1'b1) @(posedge mclk);
    run(OP_RD_CFG, 12'h000);
    check(rdata, 12'h0E3);
  endtask

  task automatic t_cont();
    run(OP_WR_CFG, 12'h002);
    run(OP_RD_CFG, 12'h000);
    check(rdata, 12'h092);
    sample_value <= 12'h7FF;
    run(OP_START, 12'h000);
    run(OP_RD_CFG, 12'h000);
    check(rdata, 12'h042);
    run(OP_STOP, 12'h000);
    check({11'h0, conv_busy}, 12'h000);
    run(OP_RD_MEAS, 12'h000);
    check(rdata, 12'h7F8);
  endtask

  task automatic t_por();
    run(OP_START, 12'h000);
    run(OP_SOFT_POR, 12'h000);
    check({11'h0, conv_busy}, 12'h000);
    run(OP_RD_MEAS, 12'h000);
    check(rdata, 12'h000);
    run(OP_RD_CFG, 12'h000);
    check(rdata, 12'h082);
    run(OP_RD_UL, 12'h000);
    check(rdata, 12'h120);
  endtask

  // --------------------
  // Sequence and watchdog
  // --------------------
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      stop_test();
    end
  end

  initial begin
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    t_reset_vals();
    t_limits();
    t_oneshot();
    t_cont();
    t_por();
    stop_test();
  end
endmodule // three_wire_thermometer_command_port_tb
